// *** design/anc_consts.svh ***
// Offsets, field positions, reset values and timing counts for the
// analog network control block. Assumes a 32-bit APB register bus.
`ifndef ANC_CONSTS_SVH
`define ANC_CONSTS_SVH

`define ANC_OFS_INT_FLAGS    8'h06
`define ANC_OFS_INT_ENABLES  8'h07
`define ANC_OFS_RES_HIGH     8'h10
`define ANC_OFS_RES_LOW      8'h11
`define ANC_OFS_RES_EXTRA    8'h12
`define ANC_OFS_CONV_CTRL    8'h13
`define ANC_OFS_CHOP_CTRL    8'h15
`define ANC_OFS_SEL_A        8'h18
`define ANC_OFS_SEL_B        8'h19
`define ANC_OFS_ENA_GAIN     8'h1A
`define ANC_OFS_AMP_SEL      8'h1B
`define ANC_OFS_FIFO_STAT    8'h1C

`define ANC_RST_BYTE         8'h00
`define ANC_CTRL_WMASK       8'h0F
`define ANC_CHOP_WMASK       8'h0C
`define ANC_ENA_WMASK        8'h8F
`define ANC_IRQ_FLAG_BIT     2
`define ANC_COMB_EN_BIT      3
`define ANC_RATE_LSB         0
`define ANC_CHOP_LSB         2
`define ANC_CONV_EN_BIT      1
`define ANC_SHORT_BIT        0
`define ANC_GAIN_LSB         2
`define ANC_REF_EN_BIT       7

`define ANC_RATE_BASE        14'd125
`define ANC_RATE_MAX_CODE    3'h6
`define ANC_CHOP_DIV_SLOW    10'd1000
`define ANC_CHOP_DIV_FAST    10'd500
`define ANC_CHOP_SLOW_CODE   2'h3
`define ANC_CHOP_FAST_CODE   2'h2
`define ANC_FIFO_DEPTH       16

`endif

// *** design/anc_pkg.sv ***
// Types shared by the analog network control block.
// Assumes anc_consts.svh supplies the numeric constants.
package anc_pkg;

    typedef struct packed {
        logic [15:0] word;
        logic [7:0]  extra;
    } anc_sample_type;

    typedef struct packed {
        logic [1:0] neg_input_select;
        logic [2:0] filter_input_select;
        logic       filter_short;
        logic [1:0] pos_path_select;
    } anc_select_a_type;

    typedef enum logic [1:0] {
        ANC_CHOP_POS_OFS = 2'b00,
        ANC_CHOP_NEG_OFS = 2'b01,
        ANC_CHOP_FAST    = 2'b10,
        ANC_CHOP_SLOW    = 2'b11
    } anc_chop_type;

endpackage : anc_pkg

// *** design/anc_fifo.sv ***
// Synchronous valid/ready FIFO used between the modulator sample input
// and the result latch. Assumes one clock and an active-low async reset.
`timescale 1ns/1ps
module anc_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    input  wire logic             i_sys_clk,  // System clock.
    input  wire logic             i_rst_b,    // Async reset, active low.
    input  wire logic             i_valid,    // Write side valid.
    output logic                  o_ready,    // Write side ready.
    input  wire logic [WIDTH-1:0] i_data,     // Write data.
    output logic                  o_valid,    // Read side valid.
    input  wire logic             i_ready,    // Read side ready.
    output logic [WIDTH-1:0]      o_data      // Read data.
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0]      cnt_reg, cnt_next;
    logic             push, pop;

    always_comb begin
        push     = i_valid && (cnt_reg != DEPTH[AW:0]);
        pop      = i_ready && (cnt_reg != '0);
        wr_next  = push ? wr_reg + 1'b1 : wr_reg;
        rd_next  = pop ? rd_reg + 1'b1 : rd_reg;
        cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        o_ready  = cnt_reg != DEPTH[AW:0];
        o_valid  = cnt_reg != '0;
        o_data   = mem_reg[rd_reg];
    end

    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            mem_reg[wr_reg] <= i_data;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
        end
    end
endmodule : anc_fifo

// *** design/anc_top.sv ***
// Register control and result logic of the analog network: amplifier and
// sigma-delta converter selects, rate and chopper dividers, result bytes.
// Assumes an APB master, a converter clock enable pulse and a modulator
// filter that offers signed samples with valid/ready, all on i_sys_clk.
//
// Operation
// - Result high/low bytes at 0x10/0x11, reset zero.
// - Bits 15 and 14 both carry sign.
// - Extra byte 0x12 extends result to 24 bits.
// - Comb enable bit 3; clear forces zero result.
// - Rate field divides converter clock 125..8000.
// - Converter result is 14-bit ratio data.
// - Chopper codes 11/10 divide clock 1000/500.
// - Codes 01/00 disable chopping, pick offset mode.
// - Select bits 7:6 choose negative input.
// - Select bits 5:3 choose filter input.
// - Select bit 2 shorts filter in to out.
// - Select bits 1:0 choose positive input.
// - Enable register bit 1 enables converter.
// - Enable register bit 0 shorts differential inputs.
`timescale 1ns/1ps
`include "anc_consts.svh"
module anc_top
    import anc_pkg::*;
#(
    parameter int FIFO_DEPTH = `ANC_FIFO_DEPTH
) (
    input  wire logic        i_sys_clk,        // System clock, 25 MHz.
    input  wire logic        i_rst_b,          // Async reset, active low.
    input  wire logic        i_psel,           // APB select.
    input  wire logic        i_penable,        // APB enable.
    input  wire logic        i_pwrite,         // APB write.
    input  wire logic [11:0] i_paddr,          // APB byte address.
    input  wire logic [31:0] i_pwdata,         // APB write data.
    output logic [31:0]      o_prdata,         // APB read data.
    output logic             o_pready,         // APB ready.
    output logic             o_pslverr,        // APB error, unmapped.
    input  wire logic        i_conv_clk_en,    // Converter clock tick.
    input  wire logic        i_mod_valid,      // Modulator sample valid.
    input  wire logic [23:0] i_mod_data,       // Modulator sample.
    output logic             o_mod_ready,      // Modulator may send.
    output logic [7:0]       o_input_select_a, // Network select A.
    output logic [7:0]       o_input_select_b, // Network select B.
    output logic [7:0]       o_amplifier_select, // Amplifier selects.
    output logic [1:0]       o_adc_gain,       // Converter input gain.
    output logic             o_ref_enable,     // Internal reference on.
    output logic             o_conv_enable,    // Converter enable.
    output logic             o_input_short,    // Inputs shorted.
    output logic             o_comb_filter_enable, // Comb filter on.
    output logic             o_chop_enable,    // Chopping active.
    output logic             o_chop_clk,       // Chopper clock.
    output logic             o_neg_offset,     // Negative offset mode.
    output logic             o_rate_tick       // Output rate strobe.
);
    logic [7:0]  int_flags_reg, int_flags_next;
    logic [7:0]  int_en_reg, int_en_next;
    logic [7:0]  ctrl_reg, ctrl_next;
    logic [7:0]  chop_reg, chop_next;
    logic [7:0]  sel_a_reg, sel_a_next;
    logic [7:0]  sel_b_reg, sel_b_next;
    logic [7:0]  ena_reg, ena_next;
    logic [7:0]  amp_reg, amp_next;
    anc_sample_type res_reg, res_next;
    logic [31:0] prdata_reg, prdata_next;
    logic        pready_reg, pready_next;
    logic        pslverr_reg, pslverr_next;
    logic [13:0] rate_cnt_reg, rate_cnt_next;
    logic        tick_reg, tick_next;
    logic [9:0]  chop_cnt_reg, chop_cnt_next;
    logic        chop_clk_reg, chop_clk_next;
    logic        fifo_valid, fifo_ready;
    logic [23:0] fifo_data;
    logic        wr_en, rd_en, rate_end, latch, irq_set;
    logic [13:0] rate_div;
    logic [9:0]  chop_half;
    anc_chop_type chop_mode;
    anc_select_a_type sel_a;

    // Divisor of the output rate: 125 shifted left by the code, top at 8000.
    function automatic logic [13:0] rate_divisor(input logic [2:0] code);
        logic [2:0] c;
        c = (code > `ANC_RATE_MAX_CODE) ? `ANC_RATE_MAX_CODE : code;
        return `ANC_RATE_BASE << c;
    endfunction : rate_divisor

    // Register write with a mask of the implemented bits.
    function automatic logic [7:0] masked(input logic [7:0] old_v,
                                          input logic [7:0] new_v,
                                          input logic [7:0] mask);
        return (old_v & ~mask) | (new_v & mask);
    endfunction : masked

    anc_fifo #(
        .WIDTH (24),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_sys_clk (i_sys_clk),
        .i_rst_b   (i_rst_b),
        .i_valid   (i_mod_valid),
        .o_ready   (o_mod_ready),
        .i_data    (i_mod_data),
        .o_valid   (fifo_valid),
        .i_ready   (fifo_ready),
        .o_data    (fifo_data)
    );

    // APB slave: one wait state, then pready raised for one cycle.
    always_comb begin
        wr_en = i_psel && i_penable && i_pwrite && !pready_reg;
        rd_en = i_psel && i_penable && !i_pwrite && !pready_reg;
        sel_a = anc_select_a_type'(sel_a_reg);
        chop_mode = anc_chop_type'(chop_reg[`ANC_CHOP_LSB +: 2]);
        rate_div = rate_divisor(ctrl_reg[`ANC_RATE_LSB +: 3]);
        rate_end = i_conv_clk_en && (rate_cnt_reg >= rate_div - 14'd1);
        // A sample is taken only at the interval boundary so that all
        // three result bytes change in one cycle.
        fifo_ready = rate_end;
        latch = rate_end && fifo_valid && ena_reg[`ANC_CONV_EN_BIT];
        irq_set = latch;

        pready_next  = i_psel && i_penable && !pready_reg;
        pslverr_next = 1'b0;
        prdata_next  = 32'h0000_0000;
        int_flags_next = int_flags_reg;
        int_en_next = int_en_reg;
        ctrl_next   = ctrl_reg;
        chop_next   = chop_reg;
        sel_a_next  = sel_a_reg;
        sel_b_next  = sel_b_reg;
        ena_next    = ena_reg;
        amp_next    = amp_reg;
        if (i_paddr[11:10] != 2'b00 || i_paddr[1:0] != 2'b00) begin
            pslverr_next = pready_next;
        end else if (wr_en) begin
            case (i_paddr[9:2])
                `ANC_OFS_INT_FLAGS:   int_flags_next = i_pwdata[7:0];
                `ANC_OFS_INT_ENABLES: int_en_next = i_pwdata[7:0];
                `ANC_OFS_CONV_CTRL:   ctrl_next = masked(ctrl_reg,
                                          i_pwdata[7:0], `ANC_CTRL_WMASK);
                `ANC_OFS_CHOP_CTRL:   chop_next = masked(chop_reg,
                                          i_pwdata[7:0], `ANC_CHOP_WMASK);
                `ANC_OFS_SEL_A:       sel_a_next = i_pwdata[7:0];
                `ANC_OFS_SEL_B:       sel_b_next = i_pwdata[7:0];
                `ANC_OFS_ENA_GAIN:    ena_next = masked(ena_reg,
                                          i_pwdata[7:0], `ANC_ENA_WMASK);
                `ANC_OFS_AMP_SEL:     amp_next = i_pwdata[7:0];
                `ANC_OFS_RES_HIGH,
                `ANC_OFS_RES_LOW,
                `ANC_OFS_RES_EXTRA,
                `ANC_OFS_FIFO_STAT:   ;
                default:              pslverr_next = 1'b1;
            endcase
        end else if (rd_en) begin
            case (i_paddr[9:2])
                `ANC_OFS_INT_FLAGS:   prdata_next[7:0] = int_flags_reg;
                `ANC_OFS_INT_ENABLES: prdata_next[7:0] = int_en_reg;
                `ANC_OFS_RES_HIGH:    prdata_next[7:0] = res_reg.word[15:8];
                `ANC_OFS_RES_LOW:     prdata_next[7:0] = res_reg.word[7:0];
                `ANC_OFS_RES_EXTRA:   prdata_next[7:0] = res_reg.extra;
                `ANC_OFS_CONV_CTRL:   prdata_next[7:0] = ctrl_reg;
                `ANC_OFS_CHOP_CTRL:   prdata_next[7:0] = chop_reg;
                `ANC_OFS_SEL_A:       prdata_next[7:0] = sel_a_reg;
                `ANC_OFS_SEL_B:       prdata_next[7:0] = sel_b_reg;
                `ANC_OFS_ENA_GAIN:    prdata_next[7:0] = ena_reg;
                `ANC_OFS_AMP_SEL:     prdata_next[7:0] = amp_reg;
                `ANC_OFS_FIFO_STAT:   prdata_next[1:0] = {fifo_valid,
                                                          o_mod_ready};
                default:              pslverr_next = 1'b1;
            endcase
        end
        // A new result sets the flag; it wins over a clearing write.
        if (irq_set) begin
            int_flags_next[`ANC_IRQ_FLAG_BIT] = 1'b1;
        end
    end

    // Result path: sign in bits 15 and 14, 14 data bits, extra low byte.
    always_comb begin
        res_next = res_reg;
        if (!ctrl_reg[`ANC_COMB_EN_BIT]) begin
            res_next = '0;
        end else if (latch) begin
            res_next.word  = {fifo_data[23], fifo_data[23],
                              fifo_data[21:8]};
            res_next.extra = fifo_data[7:0];
        end
    end

    // Output rate and chopper dividers.
    always_comb begin
        rate_cnt_next = rate_cnt_reg;
        tick_next = rate_end;
        if (!ena_reg[`ANC_CONV_EN_BIT]) begin
            rate_cnt_next = 14'd0;
            tick_next = 1'b0;
        end else if (rate_end) begin
            rate_cnt_next = 14'd0;
        end else if (i_conv_clk_en) begin
            rate_cnt_next = rate_cnt_reg + 14'd1;
        end
        chop_half = 10'd0;
        case (chop_mode)
            ANC_CHOP_SLOW:    chop_half = `ANC_CHOP_DIV_SLOW >> 1;
            ANC_CHOP_FAST:    chop_half = `ANC_CHOP_DIV_FAST >> 1;
            ANC_CHOP_NEG_OFS: chop_half = 10'd0;
            ANC_CHOP_POS_OFS: chop_half = 10'd0;
            default:          chop_half = 10'd0;
        endcase
        chop_cnt_next = 10'd0;
        chop_clk_next = 1'b0;
        if (chop_half != 10'd0) begin
            chop_clk_next = chop_clk_reg;
            if (chop_cnt_reg >= chop_half - 10'd1) begin
                chop_clk_next = !chop_clk_reg;
            end else begin
                chop_cnt_next = chop_cnt_reg + 10'd1;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            int_flags_reg <= `ANC_RST_BYTE;
            int_en_reg    <= `ANC_RST_BYTE;
            ctrl_reg      <= `ANC_RST_BYTE;
            chop_reg      <= `ANC_RST_BYTE;
            sel_a_reg     <= `ANC_RST_BYTE;
            sel_b_reg     <= `ANC_RST_BYTE;
            ena_reg       <= `ANC_RST_BYTE;
            amp_reg       <= `ANC_RST_BYTE;
            res_reg       <= '0;
            prdata_reg    <= 32'h0000_0000;
            pready_reg    <= 1'b0;
            pslverr_reg   <= 1'b0;
            rate_cnt_reg  <= 14'd0;
            tick_reg      <= 1'b0;
            chop_cnt_reg  <= 10'd0;
            chop_clk_reg  <= 1'b0;
        end else begin
            int_flags_reg <= int_flags_next;
            int_en_reg    <= int_en_next;
            ctrl_reg      <= ctrl_next;
            chop_reg      <= chop_next;
            sel_a_reg     <= sel_a_next;
            sel_b_reg     <= sel_b_next;
            ena_reg       <= ena_next;
            amp_reg       <= amp_next;
            res_reg       <= res_next;
            prdata_reg    <= prdata_next;
            pready_reg    <= pready_next;
            pslverr_reg   <= pslverr_next;
            rate_cnt_reg  <= rate_cnt_next;
            tick_reg      <= tick_next;
            chop_cnt_reg  <= chop_cnt_next;
            chop_clk_reg  <= chop_clk_next;
        end
    end

    // Outputs are straight register copies; field views follow.
    always_comb begin
        o_prdata  = prdata_reg;
        o_pready  = pready_reg;
        o_pslverr = pslverr_reg;
        o_input_select_a   = {sel_a.neg_input_select,
                              sel_a.filter_input_select,
                              sel_a.filter_short,
                              sel_a.pos_path_select};
        o_input_select_b   = sel_b_reg;
        o_amplifier_select = amp_reg;
        o_adc_gain    = ena_reg[`ANC_GAIN_LSB +: 2];
        o_ref_enable  = ena_reg[`ANC_REF_EN_BIT];
        o_conv_enable = ena_reg[`ANC_CONV_EN_BIT];
        o_input_short = ena_reg[`ANC_SHORT_BIT];
        o_comb_filter_enable = ctrl_reg[`ANC_COMB_EN_BIT];
        o_chop_enable = chop_reg[`ANC_CHOP_LSB + 1];
        o_neg_offset  = (chop_mode == ANC_CHOP_NEG_OFS);
        o_chop_clk    = chop_clk_reg;
        o_rate_tick   = tick_reg;
    end
endmodule : anc_top

// *** dv/anc_mod_model.sv ***
// Modulator side model: converter clock ticks and a sample stream.
// Assumes the block takes a sample on valid and ready at a rising edge.
`timescale 1ns/1ps
module anc_mod_model #(
    parameter int TICK_DIV = 2
) (
    input  wire logic        i_sys_clk,    // Clock.
    input  wire logic        i_rst_b,      // Reset, active low.
    input  wire logic        i_ready,      // Block takes sample.
    input  wire logic        i_stall,      // Stop offering.
    input  wire logic [23:0] i_sample,     // Sample to offer.
    output logic             o_valid,      // Sample valid.
    output logic [23:0]      o_data,       // Sample.
    output logic             o_conv_clk_en // Converter tick.
);
    int          tick_cnt;
    logic [23:0] last;
    // An offered sample stays up, unchanged, until the block takes it.
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tick_cnt <= 0;
            o_conv_clk_en <= 1'b0;
            o_valid <= 1'b0;
            last <= 24'h000000;
        end else begin
            tick_cnt <= (tick_cnt == TICK_DIV - 1) ? 0 : tick_cnt + 1;
            o_conv_clk_en <= (tick_cnt == TICK_DIV - 1);
            if (!o_valid || i_ready) begin
                o_valid <= !i_stall;
            end
            if (o_valid && i_ready) begin
                last <= o_data;
            end
        end
    end
    // Idle data shows the inverse of the last sample, never a stale copy.
    assign o_data = o_valid ? i_sample : ~last;
endmodule : anc_mod_model

// *** dv/anc_top_chk.sv ***
// Port checks for the analog network control block.
// Assumes APB answers after one wait state, pready high for one cycle.
`timescale 1ns/1ps
module anc_top_chk (
    input wire logic        i_sys_clk,      // Clock.
    input wire logic        i_rst_b,        // Reset.
    input wire logic        i_psel,         // Select.
    input wire logic        i_penable,      // Enable.
    input wire logic        i_pwrite,       // Write.
    input wire logic [11:0] i_paddr,        // Address.
    input wire logic [31:0] i_pwdata,       // Write data.
    input wire logic [31:0] o_prdata,       // Read data.
    input wire logic        o_pready,       // Ready.
    input wire logic        o_pslverr,      // Error.
    input wire logic [7:0]  o_input_select_a, // Select A.
    input wire logic        o_conv_enable,  // Converter on.
    input wire logic        o_input_short,  // Inputs shorted.
    input wire logic        o_comb_filter_enable, // Comb on.
    input wire logic        o_chop_enable,  // Chopping.
    input wire logic        o_chop_clk,     // Chopper clock.
    input wire logic        o_neg_offset,   // Offset mode.
    input wire logic        o_rate_tick     // Rate strobe.
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    logic acc;
    logic wr;
    assign acc = i_psel && i_penable && !o_pready;
    assign wr = acc && i_pwrite;
    chk_ready_wait: assert property (acc |=> o_pready)
        else $error("no ready after access");
    chk_ready_pulse: assert property (o_pready |=> !o_pready)
        else $error("ready longer than one cycle");
    chk_read_upper: assert property (
        acc && !i_pwrite |=> o_prdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    chk_sel_a_write: assert property (
        wr && i_paddr == 12'h060
        |=> o_input_select_a == $past(i_pwdata[7:0]))
        else $error("select A not written");
    chk_enable_write: assert property (
        wr && i_paddr == 12'h068
        |=> o_conv_enable == $past(i_pwdata[1])
        && o_input_short == $past(i_pwdata[0]))
        else $error("enable bits not written");
    chk_comb_zero: assert property (
        acc && !i_pwrite && i_paddr == 12'h040 && !o_comb_filter_enable
        |=> o_prdata == 32'h00000000)
        else $error("result nonzero with comb off");
    chk_offset_mode: assert property (o_neg_offset |-> !o_chop_enable)
        else $error("offset mode while chopping");
    chk_chop_idle: assert property (!o_chop_enable [*3] |-> !o_chop_clk)
        else $error("chopper clock runs when off");
    chk_unmapped_err: assert property (
        acc && i_paddr == 12'h074 |=> o_pslverr && o_pready)
        else $error("no error on unmapped");
    chk_rate_pulse: assert property (o_rate_tick |=> !o_rate_tick)
        else $error("rate strobe too long");
    cov_rate: cover property (o_rate_tick);
    cov_chop: cover property ($rose(o_chop_clk));
    cov_err: cover property (o_pslverr);
endmodule : anc_top_chk
bind anc_top anc_top_chk i_chk (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_input_select_a(o_input_select_a),
    .o_conv_enable(o_conv_enable), .o_input_short(o_input_short),
    .o_comb_filter_enable(o_comb_filter_enable),
    .o_chop_enable(o_chop_enable), .o_chop_clk(o_chop_clk),
    .o_neg_offset(o_neg_offset), .o_rate_tick(o_rate_tick)
);

// *** dv/test_adc_network_control.sv ***
// Self-checking bench for the analog network control block.
// Assumes anc_top, its bound checker and the modulator model.
`timescale 1ns/1ps
module test_adc_network_control;
    localparam int TICK_DIV = 2;
    logic        sys_clk, rst_b, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        clk_en, mod_valid, mod_ready, stall, err;
    logic [23:0] mod_data, sample;
    logic [7:0]  sel_a, sel_b, amp_sel;
    logic [1:0]  gain;
    logic        ref_en, conv_en, in_short, comb_en;
    logic        chop_en, chop_clk, neg_ofs, rate_tick;
    int          n_errors = 0;
    int          cmp_count = 0;
    int          g;
    logic [7:0]  r_ofs [11] = '{8'h10, 8'h11, 8'h12, 8'h06, 8'h07, 8'h18,
                               8'h19, 8'h1B, 8'h1A, 8'h13, 8'h15};
    logic [7:0]  r_wr  [11] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hA5,
                               8'h5A, 8'hC3, 8'hFF, 8'hF8, 8'hFF};
    logic [7:0]  r_rb  [11] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hA5,
                               8'h5A, 8'hC3, 8'h8F, 8'h08, 8'h0C};
    anc_top i_dut (
        .i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_conv_clk_en(clk_en),
        .i_mod_valid(mod_valid), .i_mod_data(mod_data),
        .o_mod_ready(mod_ready), .o_input_select_a(sel_a),
        .o_input_select_b(sel_b), .o_amplifier_select(amp_sel),
        .o_adc_gain(gain), .o_ref_enable(ref_en), .o_conv_enable(conv_en),
        .o_input_short(in_short), .o_comb_filter_enable(comb_en),
        .o_chop_enable(chop_en), .o_chop_clk(chop_clk),
        .o_neg_offset(neg_ofs), .o_rate_tick(rate_tick)
    );
    anc_mod_model #(.TICK_DIV(TICK_DIV)) i_mod (
        .i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_ready(mod_ready),
        .i_stall(stall), .i_sample(sample), .o_valid(mod_valid),
        .o_data(mod_data), .o_conv_clk_en(clk_en)
    );
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task conclude;
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude
    task check(input logic [31:0] seen, input logic [31:0] exp,
               input string what);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s %h not %h", $time, what,
                     seen, exp);
        end
    endtask : check
    // Word index times four is the byte address.
    task apb(input logic w, input logic [7:0] ofs, input logic [7:0] d);
        int n;
        begin
            @(posedge sys_clk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= {2'b00, ofs, 2'b00};
            pwdata <= {24'h000000, d};
            @(posedge sys_clk);
            penable <= 1'b1;
            n = 0;
            do begin
                @(posedge sys_clk);
                n++;
            end while (pready !== 1'b1 && n < 50);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            if (n >= 50) begin
                n_errors++;
                conclude();
            end
        end
    endtask : apb
    task rchk(input logic [7:0] ofs, input logic [7:0] exp);
        apb(1'b0, ofs, 8'h00);
        check(rd, {24'h000000, exp}, "register");
    endtask : rchk
    // Cycles between two rate strobes, or two chopper clock rises.
    task gap(input logic ch);
        int n_ev;
        int k;
        logic prev;
        logic ev;
        begin
            n_ev = 0;
            k = 0;
            g = 0;
            prev = 1'b1;
            while (n_ev < 2 && k < 40000) begin
                @(posedge sys_clk);
                k++;
                ev = ch ? (chop_clk === 1'b1 && prev === 1'b0)
                        : (rate_tick === 1'b1);
                prev = chop_clk;
                if (n_ev == 1) g++;
                if (ev) n_ev++;
            end
            if (n_ev < 2) begin
                n_errors++;
                conclude();
            end
        end
    endtask : gap
    initial begin
        rst_b = 1'b0;
        {psel, penable, pwrite, stall} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        sample = {2'b10, 14'h1234, 8'h5A};
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 11; i++) begin
            apb(1'b1, r_ofs[i], r_wr[i]);
            rchk(r_ofs[i], r_rb[i]);
        end
        @(negedge sys_clk);
        check({8'h00, sel_b, sel_a, amp_sel}, 32'h005AA5C3, "sel");
        check({27'h0, ref_en, gain, conv_en, in_short},
              32'h1F, "en");
        check({30'h0, comb_en, chop_en}, 32'h3, "comb chop");
        for (int c = 3; c >= 0; c--) begin
            apb(1'b1, 8'h15, 8'(c << 2));
            @(negedge sys_clk);
            check({30'h0, chop_en, neg_ofs},
                  {30'h0, c[1], c == 1}, "mode");
            if (c >= 2) begin
                gap(1'b1);
                check(g, (c == 3) ? 1000 : 500, "chop period");
            end
        end
        rchk(8'h10, 8'hD2);
        rchk(8'h11, 8'h34);
        rchk(8'h12, 8'h5A);
        apb(1'b1, 8'h13, 8'h0F);
        repeat (20) @(posedge sys_clk);
        check({31'h0, mod_ready}, 32'h0, "full");
        rchk(8'h1C, 8'h02);
        apb(1'b1, 8'h13, 8'h07);
        rchk(8'h10, 8'h00);
        rchk(8'h11, 8'h00);
        stall <= 1'b1;
        apb(1'b1, 8'h13, 8'h08);
        repeat (9) gap(1'b0);
        rchk(8'h1C, 8'h01);
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, 8'h13, 8'(8 + c));
            if (c != 6) begin
                gap(1'b0);
                check(g,
                      TICK_DIV * ((c > 5) ? 8000 : 125 << c), "rate");
            end
        end
        apb(1'b0, 8'h1D, 8'h00);
        check({31'h0, err}, 32'h1, "unmapped");
        rst_b <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 11; i++) rchk(r_ofs[i], 8'h00);
        check({8'h00, sel_b, sel_a, amp_sel}, 32'h0, "reset sel");
        conclude();
    end
endmodule : test_adc_network_control
